//--- hw/ccg_pkg.sv
// package: register map, field layout, reset values and timing figures of the clock generator
package ccg_pkg;

    // bus geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MULT = 8'h04;
    localparam logic [7:0] OFS_OSC  = 8'h08;
    localparam logic [7:0] OFS_CFG  = 8'h0C;
    localparam logic [7:0] OFS_STAT = 8'h10;

    // control register fields
    localparam int unsigned CTRL_INT_REQ = 0;
    localparam int unsigned CTRL_EXT_REQ = 1;
    localparam int unsigned CTRL_BUS_EXT = 2;

    // configuration register fields
    localparam int unsigned CFG_EXT_OK  = 0;
    localparam int unsigned CFG_XTAL_OK = 1;
    localparam int unsigned CFG_KEEP    = 2;

    // status register fields
    localparam int unsigned ST_HALT  = 0;
    localparam int unsigned ST_INT   = 1;
    localparam int unsigned ST_EXT   = 2;
    localparam int unsigned ST_PIN6  = 3;
    localparam int unsigned ST_PIN7  = 4;
    localparam int unsigned ST_EOSC  = 8;

    // oscillator control layout
    localparam int unsigned OSC_DIV_LSB = 8;
    localparam logic [3:0]  OSC_DIV_MAX = 4'h9;
    localparam logic [11:0] OSC_MAX     = 12'h9FF;

    // reset values
    localparam logic       RST_INT_REQ = 1'b1;
    localparam logic [6:0] RST_MULT    = 7'h04;
    localparam logic [3:0] RST_DIV     = 4'h0;
    localparam logic [7:0] RST_STG     = 8'h00;

    // nominal figures of the base clock and bus step, in Hz
    localparam int unsigned BASE_NOM_HZ = 307200;
    localparam int unsigned BUS_STEP_HZ = 76800;
    localparam int unsigned CLK_HZ      = 125000000;

    // divider output runs at half the source, bus clock at a quarter
    localparam int unsigned GEN_RATIO = 2;
    localparam int unsigned BUS_RATIO = 4;

    // software request bits travel together
    typedef struct packed {
        logic int_req;
        logic ext_req;
        logic bus_ext;
    } ccg_ctrl_t;

    // option bits travel together
    typedef struct packed {
        logic ext_ok;
        logic xtal_ok;
        logic keep;
    } ccg_cfg_t;

endpackage : ccg_pkg

//--- hw/ccg_mod_div.sv
// modulo N divider making the base clock from the internal clock
`timescale 1ns/10ps

module ccg_mod_div
    import ccg_pkg::*;
(
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // generator enable and source
    input  wire logic       run_i,
    input  wire logic       int_clk_i,
    input  wire logic [6:0] n_i,
    // divided output
    output logic            base_o
);

    typedef struct packed {
        logic [6:0] cnt;
        logic       prev;
        logic       base;
    } ccg_div_st_t;

    ccg_div_st_t s_r;
    ccg_div_st_t s_nxt;

    // next state of the divider
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.prev = int_clk_i;
        if (!run_i)
        begin
            s_nxt.cnt  = 7'h00;
            s_nxt.base = 1'b0;
        end
        else if (n_i <= 7'h01)
        begin
            s_nxt.base = int_clk_i;
        end
        else if (int_clk_i && !s_r.prev)
        begin
            s_nxt.cnt  = (s_r.cnt >= n_i - 7'h01) ? 7'h00 : s_r.cnt + 7'h01;
            s_nxt.base = (s_nxt.cnt < (n_i >> 1));
        end
    end

    // state register
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign base_o = s_r.base; // straight from the flop

endmodule // ccg_mod_div

//--- hw/ccg_top.sv
// clock generator enables, pin sharing, oscillator model and divided clocks
`timescale 1ns/10ps

module ccg_top
    import ccg_pkg::*;
(
    // clock and reset
    input  wire logic              CLK_I,
    input  wire logic              RST_N_I,
    // register port
    input  wire logic [ADDR_W-1:0] ADDR_I,
    input  wire logic [DATA_W-1:0] WDATA_I,
    input  wire logic              WR_I,
    input  wire logic              RD_I,
    output logic      [DATA_W-1:0] RDATA_O,
    // stop mode from system logic, external clock pin
    input  wire logic              STOP_I,
    input  wire logic              EXT_CLK_I,
    // generated clocks
    output logic                   OSC_OUT_CLK_O,
    output logic                   GEN_OUT_CLK_O,
    output logic                   BUS_CLK_O,
    output logic                   TIMEBASE_CLK_O,
    output logic                   INT_CLK_O,
    output logic                   EXT_CLK_O,
    output logic                   BASE_CLK_O,
    // enables
    output logic                   GEN_HALT_O,
    output logic                   INT_GEN_ON_O,
    output logic                   EXT_GEN_ON_O,
    output logic                   PIN6_PORT_ON_O,
    output logic                   PIN7_PORT_ON_O
);

    // whole state of the block
    typedef struct packed {
        ccg_ctrl_t   ctrl;
        ccg_cfg_t    cfg;
        logic [6:0]  mult;
        logic [3:0]  odiv;
        logic [7:0]  ostg;
        logic        halt;
        logic        int_on;
        logic        ext_on;
        logic        pin6;
        logic        pin7;
        logic        ext_s1;
        logic        ext_s2;
        logic        ext_clk;
        logic [11:0] dco_cnt;
        logic        int_clk;
        logic        osc_out;
        logic        gen_out;
        logic        bus_clk;
        logic        tb_clk;
        logic [31:0] rdata;
    } ccg_state_t;

    ccg_state_t s_r;
    ccg_state_t s_nxt;
    logic       base_clk;

    // effective oscillator setting, divider clamped to the slowest code
    function automatic logic [11:0] eff_osc(input logic [3:0] dv, input logic [7:0] st);
        logic [3:0] d;
        d = dv;
        if (dv > OSC_DIV_MAX)
            d = OSC_DIV_MAX;
        return {d, st};
    endfunction

    // reset value of the state
    function automatic ccg_state_t rst_state();
        ccg_state_t v;
        v = '0;
        v.ctrl.int_req = RST_INT_REQ;
        v.mult         = RST_MULT;
        v.odiv         = RST_DIV;
        v.ostg         = RST_STG;
        v.pin6         = 1'b1;
        v.pin7         = 1'b1;
        return v;
    endfunction

    // next state: registers, enables, oscillator model, clock dividers
    always_comb
    begin
        logic src;
        logic rise;
        src   = 1'b0;
        rise  = 1'b0;
        s_nxt = s_r;

        // register writes
        if (WR_I)
        begin
            case (ADDR_I)
                OFS_CTRL:
                begin
                    s_nxt.ctrl.int_req = WDATA_I[CTRL_INT_REQ];
                    s_nxt.ctrl.ext_req = WDATA_I[CTRL_EXT_REQ] & s_r.cfg.ext_ok;
                    s_nxt.ctrl.bus_ext = WDATA_I[CTRL_BUS_EXT];
                end
                OFS_MULT:
                begin
                    s_nxt.mult = WDATA_I[6:0];
                end
                OFS_OSC:
                begin
                    s_nxt.odiv = WDATA_I[OSC_DIV_LSB +: 4];
                    s_nxt.ostg = WDATA_I[7:0];
                end
                OFS_CFG:
                begin
                    s_nxt.cfg.ext_ok  = WDATA_I[CFG_EXT_OK];
                    s_nxt.cfg.xtal_ok = WDATA_I[CFG_XTAL_OK];
                    s_nxt.cfg.keep    = WDATA_I[CFG_KEEP];
                end
                default:
                begin
                    s_nxt.mult = s_r.mult; // unmapped write ignored
                end
            endcase
        end

        // register reads, data valid the cycle after the strobe only
        s_nxt.rdata = 32'h0000_0000;
        if (RD_I)
        begin
            case (ADDR_I)
                OFS_CTRL:
                begin
                    s_nxt.rdata[CTRL_INT_REQ] = s_r.ctrl.int_req;
                    s_nxt.rdata[CTRL_EXT_REQ] = s_r.ctrl.ext_req;
                    s_nxt.rdata[CTRL_BUS_EXT] = s_r.ctrl.bus_ext;
                end
                OFS_MULT:
                begin
                    s_nxt.rdata[6:0] = s_r.mult;
                end
                OFS_OSC:
                begin
                    s_nxt.rdata[11:0] = {s_r.odiv, s_r.ostg};
                end
                OFS_CFG:
                begin
                    s_nxt.rdata[CFG_EXT_OK]  = s_r.cfg.ext_ok;
                    s_nxt.rdata[CFG_XTAL_OK] = s_r.cfg.xtal_ok;
                    s_nxt.rdata[CFG_KEEP]    = s_r.cfg.keep;
                end
                OFS_STAT:
                begin
                    s_nxt.rdata[ST_HALT] = s_r.halt;
                    s_nxt.rdata[ST_INT]  = s_r.int_on;
                    s_nxt.rdata[ST_EXT]  = s_r.ext_on;
                    s_nxt.rdata[ST_PIN6] = s_r.pin6;
                    s_nxt.rdata[ST_PIN7] = s_r.pin7;
                    s_nxt.rdata[ST_EOSC +: 12] = eff_osc(s_r.odiv, s_r.ostg);
                end
                default:
                begin
                    s_nxt.rdata = 32'h0000_0000; // unmapped reads zero
                end
            endcase
        end

        // halt in stop unless kept running
        s_nxt.halt = STOP_I & ~s_r.cfg.keep;

        s_nxt.int_on = s_r.ctrl.int_req & ~s_r.halt;
        s_nxt.ext_on = s_r.ctrl.ext_req & ~s_r.halt;

        // pin6 port off when external wanted
        // no halt term, pin stays claimed in stop
        s_nxt.pin6 = ~s_r.ctrl.ext_req;
        // pin7 port off for crystal use
        s_nxt.pin7 = ~(s_r.ctrl.ext_req & s_r.cfg.xtal_ok);

        // external pin passes two flops before use
        s_nxt.ext_s1 = EXT_CLK_I;
        s_nxt.ext_s2 = s_r.ext_s1;
        // external clock gated by its enable
        // halt drops the enable, so the clock stops
        s_nxt.ext_clk = s_r.ext_s2 & s_r.ext_on;

        // oscillator model: half period follows the setting
        if (!s_r.int_on)
        begin
            s_nxt.dco_cnt = 12'h000;
            s_nxt.int_clk = 1'b0;
        end
        else if (s_r.dco_cnt == 12'h000)
        begin
            // larger setting gives a slower clock
            s_nxt.dco_cnt = eff_osc(s_r.odiv, s_r.ostg);
            s_nxt.int_clk = ~s_r.int_clk;
        end
        else
        begin
            s_nxt.dco_cnt = s_r.dco_cnt - 12'h001;
        end

        src = s_r.ctrl.bus_ext ? s_r.ext_clk : s_r.int_clk;
        s_nxt.osc_out = src;
        rise = src & ~s_r.osc_out;

        // gen toggles per source rise, bus per gen rise
        if (rise)
        begin
            s_nxt.gen_out = ~s_r.gen_out;
            if (!s_r.gen_out)
                s_nxt.bus_clk = ~s_r.bus_clk;
        end

        // timebase follows external clock when present
        s_nxt.tb_clk = s_r.ext_on ? s_r.ext_clk : s_r.int_clk;
    end

    // state register; reset leaves the internal generator requested
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            s_r <= rst_state();
        else
            s_r <= s_nxt;
    end

    // base is the internal clock over N
    ccg_mod_div u_div
    (
        .clk_i     (CLK_I),
        .rst_n_i   (RST_N_I),
        .run_i     (s_r.int_on),
        .int_clk_i (s_r.int_clk),
        .n_i       (s_r.mult),
        .base_o    (base_clk)
    );

    // outputs straight from flops
    assign RDATA_O        = s_r.rdata;
    assign OSC_OUT_CLK_O  = s_r.osc_out;
    assign GEN_OUT_CLK_O  = s_r.gen_out;
    assign BUS_CLK_O      = s_r.bus_clk;
    assign TIMEBASE_CLK_O = s_r.tb_clk;
    assign INT_CLK_O      = s_r.int_clk;
    assign EXT_CLK_O      = s_r.ext_clk;
    assign BASE_CLK_O     = base_clk;
    assign GEN_HALT_O     = s_r.halt;
    assign INT_GEN_ON_O   = s_r.int_on;
    assign EXT_GEN_ON_O   = s_r.ext_on;
    assign PIN6_PORT_ON_O = s_r.pin6;
    assign PIN7_PORT_ON_O = s_r.pin7;

endmodule // ccg_top

//--- verif/ccg_top_props.sv
// checker: port relations of the clock generator enables and gated clocks
`timescale 1ns/10ps

module ccg_top_chk
    import ccg_pkg::*;
(
    // clock and reset
    input wire logic              CLK_I,
    input wire logic              RST_N_I,
    // watched ports
    input wire logic              RD_I,
    input wire logic [DATA_W-1:0] RDATA_O,
    input wire logic              STOP_I,
    input wire logic              INT_CLK_O,
    input wire logic              EXT_CLK_O,
    input wire logic              BASE_CLK_O,
    input wire logic              GEN_HALT_O,
    input wire logic              INT_GEN_ON_O,
    input wire logic              EXT_GEN_ON_O,
    input wire logic              PIN6_PORT_ON_O,
    input wire logic              PIN7_PORT_ON_O
);
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    // clocks lag their enable by flop stages, so wait before judging
    sequence halt_held;
        GEN_HALT_O [*4];
    endsequence
    sequence int_off;
        !INT_GEN_ON_O [*3];
    endsequence

    chk_halt_cause: assert property (GEN_HALT_O |-> $past(STOP_I))
        else $error("halt without stop");
    chk_halt_int: assert property (GEN_HALT_O |=> !INT_GEN_ON_O)
        else $error("int enable during halt");
    chk_halt_ext: assert property (GEN_HALT_O |=> !EXT_GEN_ON_O)
        else $error("ext enable during halt");
    chk_int_low: assert property (int_off |-> !INT_CLK_O && !BASE_CLK_O)
        else $error("int clocks run while off");
    chk_ext_low: assert property (!EXT_GEN_ON_O [*2] |-> !EXT_CLK_O)
        else $error("ext clock runs while off");
    chk_halt_stops: assert property (halt_held |-> !(INT_CLK_O | EXT_CLK_O | BASE_CLK_O))
        else $error("clock runs in halt");
    chk_pin6_ext: assert property (EXT_GEN_ON_O |-> !PIN6_PORT_ON_O)
        else $error("pin6 port on with ext");
    chk_pin7_pin6: assert property (!PIN7_PORT_ON_O |-> !PIN6_PORT_ON_O)
        else $error("pin7 off without ext");
    chk_pin_halt: assert property ($rose(GEN_HALT_O) |-> $stable(PIN6_PORT_ON_O) && $stable(PIN7_PORT_ON_O))
        else $error("pin enable follows halt");
    chk_rdata_idle: assert property (!$past(RD_I) |-> RDATA_O == '0)
        else $error("read data outside slot");
endmodule // ccg_top_chk

bind ccg_top ccg_top_chk u_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .STOP_I(STOP_I), .INT_CLK_O(INT_CLK_O), .EXT_CLK_O(EXT_CLK_O), .BASE_CLK_O(BASE_CLK_O),
    .GEN_HALT_O(GEN_HALT_O), .INT_GEN_ON_O(INT_GEN_ON_O), .EXT_GEN_ON_O(EXT_GEN_ON_O),
    .PIN6_PORT_ON_O(PIN6_PORT_ON_O), .PIN7_PORT_ON_O(PIN7_PORT_ON_O));

//--- verif/ccg_sim_partner.sv
// far-side model: system stop level and external clock source
`timescale 1ns/10ps

module ccg_sim_partner
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // bench requests
    input  wire logic stop_req_i,
    input  wire logic ext_run_i,
    // toward the block
    output logic      stop_o,
    output logic      ext_pin_o
);
    logic [1:0] ph_r;

    // idle pin toggles each cycle so a missing gate shows up
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            stop_o    <= 1'b0;
            ext_pin_o <= 1'b0;
            ph_r      <= 2'h0;
        end
        else
        begin
            stop_o <= stop_req_i;
            ph_r   <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
            if (!ext_run_i || ph_r == 2'h2)
                ext_pin_o <= ~ext_pin_o;
        end
    end
endmodule // ccg_sim_partner

//--- verif/testbench.sv
// bench: register port, enables, pin sharing and clock ratios
`timescale 1ns/10ps

module testbench;
    import ccg_pkg::*;
    logic        CLK_I;
    logic        RST_N_I;
    logic [7:0]  ADDR_I;
    logic [31:0] WDATA_I;
    logic        WR_I;
    logic        RD_I;
    wire  [31:0] RDATA_O;
    wire         STOP_I;
    wire         EXT_CLK_I;
    wire  [6:0]  ck;
    logic [6:0]  ck_d;
    logic        stop_req;
    logic        ext_run;
    logic        rd_d;
    logic [7:0]  stg;
    int          cnt [7];
    int          c0 [7];
    int          nv [4] = '{0, 1, 3, 4};
    int          failures;
    int          check_count;
    int          seed;
    logic [31:0] expq [$];

    ccg_top DUT (.CLK_I, .RST_N_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O, .STOP_I,
        .EXT_CLK_I, .OSC_OUT_CLK_O(ck[0]), .GEN_OUT_CLK_O(ck[1]), .BUS_CLK_O(ck[2]),
        .TIMEBASE_CLK_O(ck[3]), .INT_CLK_O(ck[4]), .EXT_CLK_O(ck[5]), .BASE_CLK_O(ck[6]),
        .GEN_HALT_O(), .INT_GEN_ON_O(), .EXT_GEN_ON_O(), .PIN6_PORT_ON_O(),
        .PIN7_PORT_ON_O());
    ccg_sim_partner u_far (.clk_i(CLK_I), .rst_n_i(RST_N_I), .stop_req_i(stop_req),
        .ext_run_i(ext_run), .stop_o(STOP_I), .ext_pin_o(EXT_CLK_I));

    // 125 MHz clock
    initial
    begin
        CLK_I = 1'b0;
        forever #4 CLK_I = ~CLK_I;
    end

    task automatic report_and_stop();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic cmp(logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            failures++;
            $display("[ERR] rdata exp %h got %h", e, g);
        end
    endtask

    // window edges cut a period, so one rise of slack; a stopped clock gets none
    task automatic cmp_n(int i, int e);
        int g;
        g = cnt[i] - c0[i];
        check_count++;
        if (g > e + 1 || g < e - 1 || (e == 0 && g != 0))
        begin
            failures++;
            $display("[ERR] rises%0d exp %0d got %0d", i, e, g);
        end
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge CLK_I);
        ADDR_I  <= a;
        WDATA_I <= d;
        WR_I    <= 1'b1;
        @(posedge CLK_I);
        WR_I    <= 1'b0;
    endtask

    task automatic rd(logic [7:0] a, logic [31:0] e);
        @(posedge CLK_I);
        ADDR_I <= a;
        RD_I   <= 1'b1;
        expq.push_back(e);
        @(posedge CLK_I);
        RD_I   <= 1'b0;
    endtask

    task automatic meas(int n);
        repeat (n) @(posedge CLK_I);
        @(negedge CLK_I);
        c0 = cnt;
        repeat (480) @(negedge CLK_I);
    endtask

    // read data in the slot after the strobe; rising edges of each clock
    always @(posedge CLK_I)
    begin
        if (rd_d && expq.size() > 0)
            cmp(expq.pop_front(), RDATA_O);
        rd_d <= RD_I;
        for (int i = 0; i < 7; i++)
            cnt[i] += int'(ck[i] && !ck_d[i]);
        ck_d <= ck;
    end

    // hang guard
    initial
    begin
        repeat (20000) @(posedge CLK_I);
        failures++;
        report_and_stop();
    end

    initial
    begin
        seed = 32'he9a9;
        {RST_N_I, WR_I, RD_I, stop_req, ext_run} = 5'h00;
        ADDR_I = 8'h00;
        WDATA_I = 32'h0;
        repeat (8) @(posedge CLK_I);
        RST_N_I <= 1'b1;
        // reset values, unmapped address, ext request refused
        rd(OFS_CTRL, 32'h1);
        rd(OFS_MULT, 32'h4);
        rd(8'h14, 32'h0);
        rd(OFS_STAT, 32'h1A);
        wr(OFS_CTRL, 32'h3);
        rd(OFS_CTRL, 32'h1);
        // divider codes above nine act as nine
        for (int d = 0; d < 16; d++)
        begin
            stg = 8'($random(seed));
            wr(OFS_OSC, {20'h0, 4'(d), stg});
            rd(OFS_STAT, {12'h0, (d > 9) ? 4'h9 : 4'(d), stg, 8'h1A});
        end
        wr(OFS_OSC, 32'h0);
        // a long half period may still be counting: cycle the generator off and on
        wr(OFS_CTRL, 32'h0);
        rd(OFS_STAT, 32'h18);
        wr(OFS_CTRL, 32'h1);
        // base divider ratios, bypass at zero and one
        foreach (nv[k])
        begin
            wr(OFS_MULT, 32'(nv[k]));
            meas(20);
            cmp_n(4, 240);
            cmp_n(6, (nv[k] > 1) ? 240 / nv[k] : 240);
        end
        cmp_n(1, 120);
        cmp_n(2, 60);
        cmp_n(3, 240);
        cmp_n(5, 0);
        // external source allowed with crystal, then picked for the bus
        ext_run <= 1'b1;
        wr(OFS_CFG, 32'h3);
        wr(OFS_CTRL, 32'h3);
        rd(OFS_CTRL, 32'h3);
        rd(OFS_STAT, 32'h06);
        meas(4);
        cmp_n(5, 80);
        cmp_n(3, 80);
        wr(OFS_CTRL, 32'h7);
        meas(20);
        cmp_n(0, 80);
        cmp_n(2, 20);
        // stop halts all clocks unless keep is set, shared pins stay off
        stop_req <= 1'b1;
        repeat (6) @(posedge CLK_I);
        rd(OFS_STAT, 32'h01);
        meas(0);
        cmp_n(4, 0);
        cmp_n(5, 0);
        cmp_n(6, 0);
        stop_req <= 1'b0;
        wr(OFS_CFG, 32'h7);
        stop_req <= 1'b1;
        repeat (6) @(posedge CLK_I);
        rd(OFS_STAT, 32'h06);
        meas(0);
        cmp_n(4, 240);
        cmp_n(5, 80);
        repeat (4) @(posedge CLK_I);
        if (expq.size() != 0)
            failures++;
        report_and_stop();
    end
endmodule // testbench
